// ==== interval_timer_channel_bench.sv ====
// Self-checking bench of the interval timer channel.
// Assumes one core clock; the bench drives every channel port itself.
`timescale 1ns/100ps
`default_nettype none
module interval_timer_channel_bench;
  // ----------------------------------------------------------------
  // Signals, tasks and expectations
  // ----------------------------------------------------------------
  localparam logic [15:0] TPS_LUT [5] = '{16'h3210, 16'h3210, 16'h3210,
    16'h3210, 16'h3214};
  localparam int DIV_LUT [5] = '{1, 4, 2, 8, 16};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  itc_pkg::itc_bus_req_t bus_req = '0;
  logic timer_input_pin = 1'b0;
  logic external_irq_pin = 1'b0;
  logic master_trig_in = 1'b0;
  wire logic [15:0] bus_rdata;
  wire logic timer_output_bit;
  wire logic master_trig_out;
  wire logic channel_zero_irq;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h268b;
  int per;
  logic [15:0] n;
  logic [15:0] rv;

  always #50 core_clk = ~core_clk;

  itc_channel itc_channel_i (.core_clk(core_clk), .reset(reset),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .timer_input_pin(timer_input_pin), .external_irq_pin(external_irq_pin),
    .master_trig_in(master_trig_in), .timer_output_bit(timer_output_bit),
    .master_trig_out(master_trig_out), .channel_zero_irq(channel_zero_irq));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe lowered on the edge that takes it, so calls never overlap
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [15:0] m,
    input logic [15:0] e);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    check(bus_rdata & m, e);
  endtask

  function automatic logic [15:0] mode_w(int cks, int ccs, int mst,
    int cis, int md, int md0);
    return {2'(cks), 1'b0, 1'(ccs), 1'(mst), 3'h0, 2'(cis), 2'h0, 3'(md),
      1'(md0)};
  endfunction

  task automatic go(input logic [15:0] m, input logic [15:0] c);
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0002);
    wr(itc_pkg::ITC_ADDR_MODE, m);
    wr(itc_pkg::ITC_ADDR_COMPARE, c);
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0001);
  endtask

  // Cycles between the first and the last of want trigger pulses
  task automatic trig_wait(input int want, output int cyc);
    int hit;
    hit = 0;
    cyc = 0;
    for (int i = 0; i < 6000 && hit < want; i++) begin
      @(posedge core_clk);
      #1;
      if (hit > 0) cyc++;
      if (master_trig_out === 1'b1) hit++;
    end
    if (hit < want) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic pin_edge(input logic v, input int ext);
    @(posedge core_clk);
    if (ext == 1) external_irq_pin <= v;
    else timer_input_pin <= v;
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    chk_rd(itc_pkg::ITC_ADDR_IRQ_MASK, 16'hFFFF, 16'h00FF);
    chk_rd(itc_pkg::ITC_ADDR_PRESCALE, 16'hFFFF, 16'h0000);
    chk_rd(4'hF, 16'hFFFF, 16'h0000);
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0001);
    chk_rd(itc_pkg::ITC_ADDR_CONTROL, 16'h0001, 16'h0000);
    wr(itc_pkg::ITC_ADDR_CLK_GATE, 16'h0001);
    rv = 16'($random(seed));
    wr(itc_pkg::ITC_ADDR_COMPARE, rv);
    chk_rd(itc_pkg::ITC_ADDR_COMPARE, 16'hFFFF, rv);
    for (int k = 0; k < 5; k++) begin
      n = 16'h0002 + 16'($random(seed) & 7);
      wr(itc_pkg::ITC_ADDR_PRESCALE, TPS_LUT[k]);
      go(mode_w(k, 0, 1, 0, itc_pkg::ITC_MD_INTERVAL, 0), n);
      trig_wait(2, per);
      check(16'(per), 16'((n + 1) * DIV_LUT[k]));
    end
    go(mode_w(0, 0, 0, 0, itc_pkg::ITC_MD_INTERVAL, 0), 16'h0001);
    per = 0;
    repeat (200) begin
      @(posedge core_clk);
      #1;
      if (master_trig_out !== 1'b0) per++;
    end
    check(16'(per), 16'h0000);
    chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'h0040);
    check({15'h0, channel_zero_irq}, 16'h0000);
    wr(itc_pkg::ITC_ADDR_IRQ_MASK, 16'h00BF);
    @(posedge core_clk);
    #1;
    check({15'h0, channel_zero_irq}, 16'h0001);
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0002);
    wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0041);
    chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'h0000);
    check({15'h0, channel_zero_irq}, 16'h0000);
    for (int b = 0; b < 2; b++) begin
      go(mode_w(0, 0, 0, 0, itc_pkg::ITC_MD_INTERVAL, b), 16'h00C8);
      chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'(b) << 6);
      wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0041);
    end
    for (int m = 0; m < 8; m++) begin
      go(mode_w(0, 0, 0, 0, m, 0), 16'h00C8);
      chk_rd(itc_pkg::ITC_ADDR_CONTROL, 16'h0001,
        {15'h0, m inside {0, 2, 3, 4, 6}});
    end
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0002);
    wr(itc_pkg::ITC_ADDR_OUT_BIT, 16'h0001);
    @(posedge core_clk);
    #1;
    check({15'h0, timer_output_bit}, 16'h0001);
    wr(itc_pkg::ITC_ADDR_OUT_GATE, 16'h0001);
    wr(itc_pkg::ITC_ADDR_OUT_BIT, 16'h0000);
    @(posedge core_clk);
    #1;
    check({15'h0, timer_output_bit}, 16'h0001);
    go(mode_w(0, 0, 1, 0, itc_pkg::ITC_MD_INTERVAL, 0), 16'h0004);
    trig_wait(1, per);
    repeat (2) @(posedge core_clk);
    #1;
    check({15'h0, timer_output_bit}, 16'h0000);
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0002);
    for (int e = 0; e < 4; e++) begin
      wr(itc_pkg::ITC_ADDR_RISE_EN, 16'(e & 1));
      wr(itc_pkg::ITC_ADDR_FALL_EN, 16'(e >> 1));
      wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0001);
      pin_edge(1'b1, 1);
      chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0001, 16'(e & 1));
      wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0001);
      pin_edge(1'b0, 1);
      chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0001, 16'(e >> 1));
    end
    go(mode_w(0, 1, 0, itc_pkg::ITC_CIS_RISE, itc_pkg::ITC_MD_EVENT, 0),
      16'h0002);
    wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040);
    for (int p = 0; p < 3; p++) begin
      chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'h0000);
      pin_edge(1'b1, 0);
      pin_edge(1'b0, 0);
    end
    chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'h0040);
    // start on fall, capture on rise
    wr(itc_pkg::ITC_ADDR_PRESCALE, 16'h0030);
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0002);
    wr(itc_pkg::ITC_ADDR_MODE, mode_w(0, 0, 0, itc_pkg::ITC_CIS_LOW_WIDTH,
      itc_pkg::ITC_MD_CAPTURE, 0) | 16'h0100);
    wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040);
    pin_edge(1'b1, 0);
    pin_edge(1'b0, 0);
    pin_edge(1'b1, 0);
    // Edges seen four cycles apart; the counter starts from zero
    chk_rd(itc_pkg::ITC_ADDR_COMPARE, 16'hFFFF, 16'h0003);
    chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'h0040);
    for (int b = 0; b < 2; b++) begin
      go(mode_w(2, 0, 0, 0, itc_pkg::ITC_MD_ONE_COUNT, b), 16'h00C8);
      wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040);
      wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0001);
      chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'(b) << 6);
    end
    wr(itc_pkg::ITC_ADDR_CONTROL, 16'h0002);
    wr(itc_pkg::ITC_ADDR_MODE,
      mode_w(0, 0, 0, 0, itc_pkg::ITC_MD_INTERVAL, 1) | 16'h0400);
    wr(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040);
    chk_rd(itc_pkg::ITC_ADDR_CONTROL, 16'h0001, 16'h0000);
    @(posedge core_clk);
    master_trig_in <= 1'b1;
    @(posedge core_clk);
    master_trig_in <= 1'b0;
    chk_rd(itc_pkg::ITC_ADDR_CONTROL, 16'h0001, 16'h0001);
    chk_rd(itc_pkg::ITC_ADDR_IRQ_FLAGS, 16'h0040, 16'h0040);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== itc_channel.sv ====
// Interval timer channel with prescaler, output gate and interrupt logic.
// Assumes a register master on the plain port and pins already synchronous.
//
// Behaviour
// - Timer unit clock runs only while the clock gate bit is one.
// - Prescaler field divides the peripheral clock by two to its value.
// - Clock select 00,01,10,11 picks prescaled clocks 0,2,1,3.
// - Count source zero counts operation clock, one counts pin edges.
// - Master bit makes the channel the master of joint operation.
// - Trigger field: software, valid edge, both edges, master interrupt.
// - Edge field: falling, rising, low width, high width measurement.
// - Mode bits choose interval, capture, event, one-count, capture-one.
// - Interval or capture with low mode bit set interrupts on start.
// - One-count retrigger ignored when low bit zero, accepted when one.
// - Interval interrupt every compare value plus one count periods.
// - Output enable off: software writes output; on: timer drives it.
// - Rise and fall enables select external pin edge detection.
// - Channel request flag at bit six shows a pending request.
`timescale 1ns/100ps
`default_nettype none
module itc_channel (
  input wire logic core_clk, // Core clock, 10 MHz
  input wire logic reset, // Asynchronous reset, active high
  input wire itc_pkg::itc_bus_req_t bus_req, // Register request
  output logic [15:0] bus_rdata, // Read data, cycle after read
  input wire logic timer_input_pin, // Timer input pin level
  input wire logic external_irq_pin, // External interrupt pin level
  input wire logic master_trig_in, // Master channel interrupt pulse
  output logic timer_output_bit, // Timer output level
  output logic master_trig_out, // Interrupt pulse to slave channels
  output logic channel_zero_irq // Interrupt request to the processor
);

  itc_pkg::itc_state_t st_reg;
  itc_pkg::itc_state_t st_next;
  logic [3:0] ck_tick;
  logic gate, ccs, master, md0, toe_on;
  logic [1:0] cks, cis;
  logic [2:0] sts, md;
  logic op_tick, rise, fall, valid_edge, start_edge, cap_edge;
  logic hw_start, hw_cap, sw_start, sw_stop;
  logic start_trig, cap_trig, count_tick;
  logic ext_rise, ext_fall, ext_ev, chan_ev, wr_tout;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign gate = st_reg.per[itc_pkg::ITC_GATE_BIT];
  assign cks = st_reg.mode[itc_pkg::ITC_CKS_LSB +: 2];
  assign ccs = st_reg.mode[itc_pkg::ITC_CCS_BIT];
  assign master = st_reg.mode[itc_pkg::ITC_MASTER_BIT];
  assign sts = st_reg.mode[itc_pkg::ITC_STS_LSB +: 3];
  assign cis = st_reg.mode[itc_pkg::ITC_CIS_LSB +: 2];
  assign md = st_reg.mode[itc_pkg::ITC_MD_LSB +: 3];
  assign md0 = st_reg.mode[itc_pkg::ITC_MD0_BIT];
  assign toe_on = st_reg.toe[itc_pkg::ITC_TOE_BIT];

  itc_prescaler itc_prescaler_i (
    .core_clk(core_clk),
    .reset(reset),
    .enable(gate),
    .sel(st_reg.tps),
    .tick(ck_tick)
  );

  assign op_tick = (cks == 2'h0) ? ck_tick[0] :
                   (cks == 2'h1) ? ck_tick[2] :
                   (cks == 2'h2) ? ck_tick[1] : ck_tick[3];

  // ----------------------------------------------------------------
  // Pin edges and triggers
  // ----------------------------------------------------------------
  assign rise = timer_input_pin && !st_reg.tin_q;
  assign fall = !timer_input_pin && st_reg.tin_q;

  assign valid_edge = (cis == itc_pkg::ITC_CIS_FALL) ? fall :
                      (cis == itc_pkg::ITC_CIS_RISE) ? rise : (rise || fall);
  assign start_edge = (cis == itc_pkg::ITC_CIS_FALL ||
                       cis == itc_pkg::ITC_CIS_LOW_WIDTH) ? fall : rise;
  assign cap_edge = (cis == itc_pkg::ITC_CIS_FALL) ? fall :
                    (cis == itc_pkg::ITC_CIS_RISE) ? rise :
                    (cis == itc_pkg::ITC_CIS_LOW_WIDTH) ? rise : fall;

  always_comb begin
    hw_start = 1'b0;
    hw_cap = 1'b0;
    case (sts)
      itc_pkg::ITC_STS_VALID_EDGE: begin
        hw_start = start_edge;
        hw_cap = cap_edge;
      end
      itc_pkg::ITC_STS_BOTH_EDGES: begin
        hw_start = rise || fall;
        hw_cap = rise || fall;
      end
      itc_pkg::ITC_STS_MASTER: begin
        hw_start = master_trig_in;
      end
      default: begin
        hw_start = 1'b0;
      end
    endcase
  end

  assign sw_start = bus_req.wr && bus_req.addr == itc_pkg::ITC_ADDR_CONTROL
                    && bus_req.wdata[itc_pkg::ITC_CTRL_START_BIT];
  assign sw_stop = bus_req.wr && bus_req.addr == itc_pkg::ITC_ADDR_CONTROL
                   && bus_req.wdata[itc_pkg::ITC_CTRL_STOP_BIT];
  // Triggers are void while the unit clock is stopped
  assign start_trig = gate && (sw_start || hw_start);
  assign cap_trig = gate && st_reg.run && hw_cap;
  assign count_tick = gate && st_reg.run && (ccs ? valid_edge : op_tick);

  assign ext_rise = external_irq_pin && !st_reg.pin_q;
  assign ext_fall = !external_irq_pin && st_reg.pin_q;
  assign ext_ev = (st_reg.egp[itc_pkg::ITC_EDGE_BIT] && ext_rise) ||
                  (st_reg.egn[itc_pkg::ITC_EDGE_BIT] && ext_fall);
  assign wr_tout = bus_req.wr && bus_req.addr == itc_pkg::ITC_ADDR_OUT_BIT;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    chan_ev = 1'b0;
    st_next.rdata = itc_pkg::ITC_WORD_RST;
    st_next.tin_q = timer_input_pin;
    st_next.pin_q = external_irq_pin;
    if (bus_req.wr) begin
      if (bus_req.addr == itc_pkg::ITC_ADDR_CLK_GATE) begin
        st_next.per = bus_req.wdata[7:0];
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_PRESCALE) begin
        st_next.tps = bus_req.wdata & itc_pkg::ITC_PRESCALE_WMASK;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_MODE) begin
        st_next.mode = bus_req.wdata & itc_pkg::ITC_MODE_WMASK;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_COMPARE) begin
        st_next.cmp = bus_req.wdata;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_OUT_GATE) begin
        st_next.toe = bus_req.wdata[7:0];
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_RISE_EN) begin
        st_next.egp = bus_req.wdata[7:0];
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_FALL_EN) begin
        st_next.egn = bus_req.wdata[7:0];
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_IRQ_FLAGS) begin
        st_next.iflag = st_reg.iflag & ~bus_req.wdata[7:0];
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_IRQ_MASK) begin
        st_next.imask = bus_req.wdata[7:0];
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == itc_pkg::ITC_ADDR_CLK_GATE) begin
        st_next.rdata = {8'h00, st_reg.per};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_PRESCALE) begin
        st_next.rdata = st_reg.tps;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_MODE) begin
        st_next.rdata = st_reg.mode;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_COMPARE) begin
        st_next.rdata = st_reg.cmp;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_OUT_GATE) begin
        st_next.rdata = {8'h00, st_reg.toe};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_OUT_BIT) begin
        st_next.rdata = {15'h0000, st_reg.tout};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_RISE_EN) begin
        st_next.rdata = {8'h00, st_reg.egp};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_FALL_EN) begin
        st_next.rdata = {8'h00, st_reg.egn};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_IRQ_FLAGS) begin
        st_next.rdata = {8'h00, st_reg.iflag};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_IRQ_MASK) begin
        st_next.rdata = {8'h00, st_reg.imask};
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_COUNTER) begin
        st_next.rdata = st_reg.cnt;
      end else if (bus_req.addr == itc_pkg::ITC_ADDR_CONTROL) begin
        st_next.rdata = {15'h0000, st_reg.run};
      end
    end

    if (sw_stop) begin
      st_next.run = 1'b0;
    end else begin
      case (md)
        itc_pkg::ITC_MD_INTERVAL, itc_pkg::ITC_MD_EVENT: begin
          if (start_trig) begin
            st_next.cnt = st_reg.cmp;
            st_next.run = 1'b1;
            chan_ev = md0 && md == itc_pkg::ITC_MD_INTERVAL;
          end else if (count_tick) begin
            if (st_reg.cnt == 16'h0000) begin
              chan_ev = 1'b1;
              st_next.cnt = st_reg.cmp;
            end else begin
              st_next.cnt = st_reg.cnt - 16'h0001;
            end
          end
        end
        itc_pkg::ITC_MD_CAPTURE, itc_pkg::ITC_MD_CAP_ONE: begin
          if (start_trig && !st_reg.run) begin
            st_next.cnt = 16'h0000;
            st_next.run = 1'b1;
            chan_ev = md0 && md == itc_pkg::ITC_MD_CAPTURE;
          end else if (cap_trig) begin
            st_next.cmp = st_reg.cnt;
            st_next.cnt = 16'h0000;
            chan_ev = 1'b1;
            st_next.run = (md == itc_pkg::ITC_MD_CAPTURE);
          end else if (count_tick) begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end
        itc_pkg::ITC_MD_ONE_COUNT: begin
          // retrigger only with low bit set
          if (start_trig && (!st_reg.run || md0)) begin
            st_next.cnt = st_reg.cmp;
            chan_ev = st_reg.run;
            st_next.run = 1'b1;
          end else if (count_tick) begin
            if (st_reg.cnt == 16'h0000) begin
              chan_ev = 1'b1;
              st_next.run = 1'b0;
            end else begin
              st_next.cnt = st_reg.cnt - 16'h0001;
            end
          end
        end
        default: begin
          // Prohibited codes hold the channel idle
          st_next.run = 1'b0;
        end
      endcase
    end

    if (toe_on && chan_ev) begin
      st_next.tout = !st_reg.tout;
    end else if (!toe_on && wr_tout) begin
      st_next.tout = bus_req.wdata[itc_pkg::ITC_TOUT_BIT];
    end

    st_next.mtrig = chan_ev && master;
    if (chan_ev) begin
      st_next.iflag[itc_pkg::ITC_IF_CHAN_BIT] = 1'b1;
    end
    if (ext_ev) begin
      st_next.iflag[itc_pkg::ITC_IF_EXT_BIT] = 1'b1;
    end
    st_next.irq = |(st_next.iflag & ~st_next.imask);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.imask <= itc_pkg::ITC_IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign timer_output_bit = st_reg.tout;
  assign master_trig_out = st_reg.mtrig;
  assign channel_zero_irq = st_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_gate_hold;
    !gate |=> $stable(st_reg.cnt);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("Counter moved while the clock gate was closed");

  property p_int_reload;
    st_reg.run && md == itc_pkg::ITC_MD_INTERVAL && count_tick &&
    st_reg.cnt == 16'h0000 && !start_trig && !sw_stop
    |=> st_reg.iflag[itc_pkg::ITC_IF_CHAN_BIT] &&
        st_reg.cnt == $past(st_reg.cmp);
  endproperty
  a_int_reload: assert property (p_int_reload)
    else $error("Interval end did not flag and reload");

  property p_int_down;
    st_reg.run && md == itc_pkg::ITC_MD_INTERVAL && count_tick &&
    st_reg.cnt != 16'h0000 && !start_trig && !sw_stop
    |=> st_reg.cnt == $past(st_reg.cnt) - 16'h0001;
  endproperty
  a_int_down: assert property (p_int_down)
    else $error("Interval counter did not step down by one");

  property p_start_irq;
    !st_reg.run && md == itc_pkg::ITC_MD_INTERVAL && md0 && start_trig &&
    !sw_stop |=> st_reg.run && st_reg.iflag[itc_pkg::ITC_IF_CHAN_BIT];
  endproperty
  a_start_irq: assert property (p_start_irq)
    else $error("Start with low mode bit set raised no request");

  property p_one_ignore;
    st_reg.run && md == itc_pkg::ITC_MD_ONE_COUNT && !md0 && start_trig &&
    !count_tick && !sw_stop |=> $stable(st_reg.cnt) && st_reg.run;
  endproperty
  a_one_ignore: assert property (p_one_ignore)
    else $error("One-count accepted a retrigger with low bit clear");

  property p_out_sw;
    !toe_on && wr_tout |=> timer_output_bit == $past(bus_req.wdata[0]);
  endproperty
  a_out_sw: assert property (p_out_sw)
    else $error("Output write ignored while the output gate was off");

  property p_out_hw;
    toe_on && wr_tout && !chan_ev |=> $stable(timer_output_bit);
  endproperty
  a_out_hw: assert property (p_out_hw)
    else $error("Output write took effect while the output gate was on");

  property p_ext_fall;
    st_reg.egn[itc_pkg::ITC_EDGE_BIT] && ext_fall
    |=> st_reg.iflag[itc_pkg::ITC_IF_EXT_BIT];
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("Falling pin edge missed with falling detect on");

  property p_flag_clear;
    bus_req.wr && bus_req.addr == itc_pkg::ITC_ADDR_IRQ_FLAGS &&
    bus_req.wdata[itc_pkg::ITC_IF_CHAN_BIT] && !chan_ev
    |=> !st_reg.iflag[itc_pkg::ITC_IF_CHAN_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Channel request flag survived a write of one");

  property p_irq_mask;
    channel_zero_irq == |(st_reg.iflag & ~st_reg.imask);
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("Interrupt output disagrees with flags and mask");

endmodule
`default_nettype wire

// ==== itc_pkg.sv ====
// Constants, register map and carrier types of the interval timer channel.
// Assumes a single core clock and the plain register port of the channel.
package itc_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] ITC_ADDR_CLK_GATE = 4'h0;
  localparam logic [3:0] ITC_ADDR_PRESCALE = 4'h1;
  localparam logic [3:0] ITC_ADDR_MODE = 4'h2;
  localparam logic [3:0] ITC_ADDR_COMPARE = 4'h3;
  localparam logic [3:0] ITC_ADDR_OUT_GATE = 4'h4;
  localparam logic [3:0] ITC_ADDR_OUT_BIT = 4'h5;
  localparam logic [3:0] ITC_ADDR_RISE_EN = 4'h6;
  localparam logic [3:0] ITC_ADDR_FALL_EN = 4'h7;
  localparam logic [3:0] ITC_ADDR_IRQ_FLAGS = 4'h8;
  localparam logic [3:0] ITC_ADDR_IRQ_MASK = 4'h9;
  localparam logic [3:0] ITC_ADDR_COUNTER = 4'hA;
  localparam logic [3:0] ITC_ADDR_CONTROL = 4'hB;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ITC_GATE_BIT = 0;
  localparam int ITC_PS_FIELD_W = 4;
  localparam int ITC_CKS_LSB = 14;
  localparam int ITC_CCS_BIT = 12;
  localparam int ITC_MASTER_BIT = 11;
  localparam int ITC_STS_LSB = 8;
  localparam int ITC_CIS_LSB = 6;
  localparam int ITC_MD_LSB = 1;
  localparam int ITC_MD0_BIT = 0;
  localparam int ITC_TOE_BIT = 0;
  localparam int ITC_TOUT_BIT = 0;
  localparam int ITC_EDGE_BIT = 0;
  localparam int ITC_IF_CHAN_BIT = 6;
  localparam int ITC_IF_EXT_BIT = 0;
  localparam int ITC_CTRL_START_BIT = 0;
  localparam int ITC_CTRL_STOP_BIT = 1;

  // Reserved bits of these registers always read as zero
  localparam logic [15:0] ITC_PRESCALE_WMASK = 16'h33FF;
  localparam logic [15:0] ITC_MODE_WMASK = 16'hDFCF;

  // ----------------------------------------------------------------
  // Mode, trigger and edge codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ITC_MD_INTERVAL = 3'h0;
  localparam logic [2:0] ITC_MD_CAPTURE = 3'h2;
  localparam logic [2:0] ITC_MD_EVENT = 3'h3;
  localparam logic [2:0] ITC_MD_ONE_COUNT = 3'h4;
  localparam logic [2:0] ITC_MD_CAP_ONE = 3'h6;
  localparam logic [2:0] ITC_STS_SOFTWARE = 3'h0;
  localparam logic [2:0] ITC_STS_VALID_EDGE = 3'h1;
  localparam logic [2:0] ITC_STS_BOTH_EDGES = 3'h2;
  localparam logic [2:0] ITC_STS_MASTER = 3'h4;
  localparam logic [1:0] ITC_CIS_FALL = 2'h0;
  localparam logic [1:0] ITC_CIS_RISE = 2'h1;
  localparam logic [1:0] ITC_CIS_LOW_WIDTH = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ITC_WORD_RST = 16'h0000;
  localparam logic [7:0] ITC_BYTE_RST = 8'h00;
  localparam logic [7:0] ITC_IRQ_MASK_RST = 8'hFF;

  // ----------------------------------------------------------------
  // Carrier and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } itc_bus_req_t;

  typedef struct packed {
    logic [7:0] per;
    logic [15:0] tps;
    logic [15:0] mode;
    logic [15:0] cmp;
    logic [7:0] toe;
    logic tout;
    logic [7:0] egp;
    logic [7:0] egn;
    logic [7:0] iflag;
    logic [7:0] imask;
    logic [15:0] cnt;
    logic run;
    logic tin_q;
    logic pin_q;
    logic mtrig;
    logic irq;
    logic [15:0] rdata;
  } itc_state_t;

  typedef struct packed {
    logic [14:0] cnt;
  } itc_ps_state_t;

endpackage

// ==== itc_prescaler.sv ====
// Prescaler of the timer unit: four power-of-two count enables.
// Assumes the select word arrives with its reserved bits already cleared.
`timescale 1ns/100ps
`default_nettype none
module itc_prescaler (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic enable, // Unit clock gate
  input wire logic [15:0] sel, // Four select fields
  output logic [3:0] tick // One-cycle enables of the four clocks
);

  itc_pkg::itc_ps_state_t st_reg;
  itc_pkg::itc_ps_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!enable) begin
      st_next.cnt = 15'h0000;
    end else begin
      st_next.cnt = st_reg.cnt + 15'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Tap decode
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_tap
      logic [14:0] tap_mask;
      // divide by two to the field
      assign tap_mask = 15'((16'h0001 <<
        sel[i*itc_pkg::ITC_PS_FIELD_W +: itc_pkg::ITC_PS_FIELD_W]) - 16'h1);
      assign tick[i] = enable && ((st_reg.cnt & tap_mask) == tap_mask);
    end
  endgenerate

endmodule
`default_nettype wire
